//--- spio_pkg.sv
// Shared constants for the shared-pin I/O port with change detection.
package spio_pkg;
  localparam int SPIO_NUM_PORTS = 3;
  localparam int SPIO_PORT_WIDTH = 16;
  localparam logic [15:0] SPIO_DIR_RESET = 16'hFFFF;
  localparam logic [15:0] SPIO_LAT_RESET = 16'h0000;
  localparam logic [15:0] SPIO_ODC_RESET = 16'h0000;
  localparam logic [15:0] SPIO_ANS_RESET = 16'hFFFF;
  localparam logic [15:0] SPIO_EDGE_RESET = 16'h0000;
  localparam logic [15:0] SPIO_FLAG_RESET = 16'h0000;
  localparam logic [15:0] SPIO_PULL_RESET = 16'h0000;
  localparam int SPIO_GLOBAL_IE_BIT = 3;
  localparam int SPIO_MODULE_EN_BIT = 15;
  localparam int SPIO_SUM_PORTA_BIT = 0;
  localparam int SPIO_SUM_PORTB_BIT = 1;
  localparam int SPIO_SUM_PORTC_BIT = 2;
  localparam int SPIO_SYNC_STAGES = 3;
endpackage : spio_pkg

//--- spio_port.sv
// One 16-bit shared-pin I/O port with edge-selective change detection.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - An enabled, driving peripheral owns the pin output; the pin stays readable.
// - Port output data never loops back into the peripheral input.
// - Direction bit 1 makes the pin an input; 0 drives the latch bit.
// - Every reset sets all direction bits so all pins are inputs.
// - Latch reads return stored latch contents; latch writes update it.
// - Pin-value reads return sampled pins; writes there go to the latch.
// - Unimplemented bits are disabled and read zero in latch, direction, pins.
// - Open-drain bit makes the output drive low only and release for high; here it is ignored on pins that a peripheral drives.
// - Analog-selected pins read zero and their digital input path is off.
// - Analog 1/dir 1 analog, 0/1 digital input, 0/0 digital output.
// - Rising enable set flags low-to-high transitions.
// - Falling enable set flags high-to-low transitions.
// - Both enables give one event per edge, two per pulse.
// - Events need global enable, module enable and a clear interrupt flag.
// - A detected edge sets the pin flag until software writes zero.
// - Summary flag is set while any flag of the port is set.
// - Hardware set beats a simultaneous software clear.
// - Edge capture must work with the system clock stopped; here edges are found only on mclk_in samples.
// - Each pin has separate weak pull-up and pull-down enables.
// - Summary bits sit at bit 0, 1, 2 for ports A, B, C; read only.
module spio_port import spio_pkg::*; #(
  parameter int WIDTH = SPIO_PORT_WIDTH,
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic lat_wr_in,
  input wire logic port_wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic dir_wr_in,
  input wire logic [WIDTH-1:0] dir_wdata_in,
  input wire logic odc_wr_in,
  input wire logic [WIDTH-1:0] odc_wdata_in,
  input wire logic ans_wr_in,
  input wire logic [WIDTH-1:0] ans_wdata_in,
  input wire logic edge_wr_in,
  input wire logic [WIDTH-1:0] rise_wdata_in,
  input wire logic [WIDTH-1:0] fall_wdata_in,
  input wire logic pull_wr_in,
  input wire logic [WIDTH-1:0] pu_wdata_in,
  input wire logic [WIDTH-1:0] pd_wdata_in,
  input wire logic flag_wr_in,
  input wire logic [WIDTH-1:0] flag_wdata_in,
  input wire logic global_ie_in,
  input wire logic module_en_in,
  input wire logic change_interrupt_flag_in,
  input wire logic [WIDTH-1:0] periph_en_in,
  input wire logic [WIDTH-1:0] periph_drive_in,
  input wire logic [WIDTH-1:0] periph_out_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_out,
  output logic [WIDTH-1:0] periph_in_out,
  output logic [WIDTH-1:0] pullup_en_out,
  output logic [WIDTH-1:0] pulldown_en_out,
  output logic [WIDTH-1:0] output_latch_bits_out,
  output logic [WIDTH-1:0] pin_direction_bits_out,
  output logic [WIDTH-1:0] pin_value_bits_out,
  output logic [WIDTH-1:0] pin_change_flags_out,
  output logic port_change_summary_flag_out
);

  if (WIDTH != SPIO_PORT_WIDTH) begin : g_width_check
    $error("spio_port: WIDTH must be 16");
  end

  // ==========================================================================
  // Configuration registers
  localparam logic [WIDTH-1:0] MASK = IMPL_MASK[WIDTH-1:0];
  logic [WIDTH-1:0] lat_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] odc_q;
  logic [WIDTH-1:0] ans_q;
  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;
  logic [WIDTH-1:0] pu_q;
  logic [WIDTH-1:0] pd_q;
  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;
  logic [WIDTH-1:0] pin_value_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lat_q <= SPIO_LAT_RESET;
      dir_q <= SPIO_DIR_RESET;
      odc_q <= SPIO_ODC_RESET;
      ans_q <= SPIO_ANS_RESET;
      rise_q <= SPIO_EDGE_RESET;
      fall_q <= SPIO_EDGE_RESET;
      pu_q <= SPIO_PULL_RESET;
      pd_q <= SPIO_PULL_RESET;
    end else begin
      // Writes to the pin-value register land in the latch.
      if (lat_wr_in || port_wr_in) begin
        lat_q <= wdata_in & MASK;
      end
      if (dir_wr_in) begin
        dir_q <= dir_wdata_in | ~MASK;
      end
      if (odc_wr_in) begin
        odc_q <= odc_wdata_in & MASK;
      end
      if (ans_wr_in) begin
        ans_q <= ans_wdata_in;
      end
      if (edge_wr_in) begin
        rise_q <= rise_wdata_in & MASK;
        fall_q <= fall_wdata_in & MASK;
      end
      if (pull_wr_in) begin
        pu_q <= pu_wdata_in & MASK;
        pd_q <= pd_wdata_in & MASK;
      end
    end
  end

  // ==========================================================================
  // Output ownership and pad drive
  wire [WIDTH-1:0] periph_owns = periph_en_in & periph_drive_in;
  wire [WIDTH-1:0] port_drives = ~dir_q & ~periph_owns & MASK;
  wire [WIDTH-1:0] out_data = (periph_owns & periph_out_in) | (~periph_owns & lat_q);
  wire [WIDTH-1:0] out_en = periph_owns | port_drives;

  // Open drain on a port-driven pin drives only a low; a high releases the pad.
  assign pin_out = out_data & ~(odc_q & ~periph_owns);
  assign pin_oe_out = out_en & ~(odc_q & ~periph_owns & lat_q);
  assign pullup_en_out = pu_q;
  assign pulldown_en_out = pd_q;

  // ==========================================================================
  // Input path: three-stage sampler, analog gating
  // Three stages, and a level counts only once the last two agree, so a
  // pad caught mid-transition never reaches the flags as a half edge.
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;
  wire [WIDTH-1:0] dig_in = ~ans_q & MASK;
  wire [WIDTH-1:0] agreed = (sync2_q == sync3_q) ? sync2_q : pin_value_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_value_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_value_q <= agreed & dig_in;
    end
  end

  // The peripheral sees the pad only; port-driven bits are masked out.
  assign periph_in_out = pin_value_q & ~port_drives;

  // ==========================================================================
  // Change detection and sticky flags
  // Edges are found on the sampled copy; in a stopped-clock sleep the pad
  // wake logic outside must hold the clock alive until the sample settles.
  logic [WIDTH-1:0] prev_q;
  wire armed = global_ie_in & module_en_in & ~change_interrupt_flag_in;
  wire [WIDTH-1:0] rise_ev = pin_value_q & ~prev_q & rise_q;
  wire [WIDTH-1:0] fall_ev = ~pin_value_q & prev_q & fall_q;
  wire [WIDTH-1:0] hw_set = (rise_ev | fall_ev) & {WIDTH{armed}};
  wire [WIDTH-1:0] sw_keep = flag_wr_in ? flag_wdata_in : {WIDTH{1'b1}};

  assign flag_d = ((flag_q & sw_keep) | hw_set) & MASK;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prev_q <= '0;
      flag_q <= SPIO_FLAG_RESET;
    end else begin
      prev_q <= pin_value_q;
      flag_q <= flag_d;
    end
  end

  assign output_latch_bits_out = lat_q;
  assign pin_direction_bits_out = dir_q & MASK;
  assign pin_value_bits_out = pin_value_q;
  assign pin_change_flags_out = flag_q;
  // The integrator places each port's summary at SPIO_SUM_PORTA_BIT, _B_ or
  // _C_ of the status word; software cannot write it.
  assign port_change_summary_flag_out = |flag_q;

  // ==========================================================================
  // Assertions
  property p_dir_reset;
    @(posedge mclk_in) $fell(rst_in) |-> (dir_q == SPIO_DIR_RESET);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir not all input after reset");

  property p_periph_owns;
    @(posedge mclk_in) disable iff (rst_in)
      (periph_en_in[0] && periph_drive_in[0]) |-> (pin_out[0] == periph_out_in[0]);
  endproperty
  a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost pin");

  property p_input_off;
    @(posedge mclk_in) disable iff (rst_in)
      (dir_q[0] && !periph_owns[0]) |-> !pin_oe_out[0];
  endproperty
  a_input_off: assert property (p_input_off) else $error("input pin driven");

  property p_port_write;
    @(posedge mclk_in) disable iff (rst_in)
      port_wr_in |=> (lat_q == ($past(wdata_in) & MASK));
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write missed latch");

  property p_od_high;
    @(posedge mclk_in) disable iff (rst_in)
      (odc_q[0] && lat_q[0] && !periph_owns[0]) |-> !pin_oe_out[0];
  endproperty
  a_od_high: assert property (p_od_high) else $error("open drain drove high");

  property p_analog_zero;
    @(posedge mclk_in) disable iff (rst_in) ans_q[0] |=> !pin_value_q[0];
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read one");

  sequence s_rise;
    !pin_value_q[0] ##1 pin_value_q[0] && rise_q[0] && armed;
  endsequence
  property p_rise_flag;
    @(posedge mclk_in) disable iff (rst_in) s_rise |=> flag_q[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge not flagged");

  property p_set_wins;
    @(posedge mclk_in) disable iff (rst_in)
      (hw_set[0] && flag_wr_in && !flag_wdata_in[0]) |=> flag_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_summary;
    @(posedge mclk_in) disable iff (rst_in)
      port_change_summary_flag_out == (flag_q != '0);
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_unarmed;
    @(posedge mclk_in) disable iff (rst_in)
      (!armed && !flag_q[0]) |=> !flag_q[0];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("flag set while disabled");

  // ==========================================================================
  // Further checks; per-bit properties watch bit 0 only, since every bit
  // comes from the same vector expression.
  property p_lat_write;
    @(posedge mclk_in) disable iff (rst_in)
      lat_wr_in |=> (output_latch_bits_out == ($past(wdata_in) & MASK));
  endproperty
  a_lat_write: assert property (p_lat_write) else $error("latch write lost");

  property p_dir_write;
    @(posedge mclk_in) disable iff (rst_in)
      dir_wr_in |=> (pin_direction_bits_out == ($past(dir_wdata_in) & MASK));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_loop_block;
    @(posedge mclk_in) disable iff (rst_in)
      (periph_in_out & port_drives) == '0;
  endproperty
  a_loop_block: assert property (p_loop_block) else $error("port output looped back");

  property p_unimpl_zero;
    @(posedge mclk_in) disable iff (rst_in)
      ((output_latch_bits_out | pin_direction_bits_out | pin_value_bits_out) & ~MASK) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("missing bit read one");

  property p_owner_release;
    @(posedge mclk_in) disable iff (rst_in)
      (periph_en_in[0] && !periph_drive_in[0] && port_drives[0] && !odc_q[0]) |-> pin_oe_out[0];
  endproperty
  a_owner_release: assert property (p_owner_release) else $error("port lost idle pin");

  property p_push_pull;
    @(posedge mclk_in) disable iff (rst_in)
      (!odc_q[0] && port_drives[0]) |-> (pin_oe_out[0] && (pin_out[0] == lat_q[0]));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

  property p_od_low;
    @(posedge mclk_in) disable iff (rst_in)
      (odc_q[0] && port_drives[0] && !lat_q[0]) |-> (pin_oe_out[0] && !pin_out[0]);
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain low not driven");

  property p_reset_input;
    @(posedge mclk_in) $fell(rst_in) |-> (port_drives == '0);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");

  property p_pull_follow;
    @(posedge mclk_in) disable iff (rst_in)
      pull_wr_in |=> ((pullup_en_out == ($past(pu_wdata_in) & MASK)) && (pulldown_en_out == ($past(pd_wdata_in) & MASK)));
  endproperty
  a_pull_follow: assert property (p_pull_follow) else $error("pull enable lost");

  // While the last two sampler stages disagree the old level must hold.
  property p_sync_agree;
    @(posedge mclk_in) disable iff (rst_in)
      (sync2_q != sync3_q) |=> (pin_value_q == ($past(pin_value_q) & $past(dig_in)));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("unsettled pin level used");

  sequence s_fall;
    pin_value_q[0] ##1 !pin_value_q[0] && fall_q[0] && armed;
  endsequence
  property p_fall_flag;
    @(posedge mclk_in) disable iff (rst_in) s_fall |=> flag_q[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge not flagged");

  property p_both_edges;
    @(posedge mclk_in) disable iff (rst_in)
      (rise_q[0] && fall_q[0] && armed && (pin_value_q[0] != prev_q[0])) |=> flag_q[0];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge of a pulse lost");

  // A flag may only drop through a zero written to it.
  property p_flag_sticky;
    @(posedge mclk_in) disable iff (rst_in)
      (flag_q[0] && !(flag_wr_in && !flag_wdata_in[0])) |=> flag_q[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

  property p_flag_clear;
    @(posedge mclk_in) disable iff (rst_in)
      (flag_wr_in && !flag_wdata_in[0] && !hw_set[0]) |=> !flag_q[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

endmodule : spio_port

`default_nettype wire

//--- spio_pads.sv
// Pad and peripheral driver model facing one port's pins.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Pad model
module spio_pads (
  input wire logic mclk_in,
  input wire logic [15:0] pad_data_in,
  input wire logic [15:0] pad_oe_in,
  input wire logic [15:0] pu_in,
  input wire logic [15:0] pd_in,
  input wire logic [15:0] drv_in,
  input wire logic [15:0] dval_in,
  input wire logic [15:0] ext_en_in,
  input wire logic [15:0] ext_in,
  output logic [15:0] level_out
);
  logic [15:0] last_q;
  // A pad that nobody holds flips each cycle, so a stale level is never read as good.
  always_ff @(posedge mclk_in) last_q <= level_out;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      level_out[i] = drv_in[i] ? dval_in[i] : pad_oe_in[i] ? pad_data_in[i] :
        ext_en_in[i] ? ext_in[i] : pu_in[i] ? 1'b1 : pd_in[i] ? 1'b0 : ~last_q[i];
    end
  end
endmodule : spio_pads
`default_nettype wire

//--- spio_port_tb.sv
// Self-checking testbench for one shared-pin port.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench
module spio_port_tb;
  import spio_pkg::*;
  localparam logic [15:0] MASK = 16'h3FFF;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lat_wr_in = 0, port_wr_in = 0, dir_wr_in = 0, odc_wr_in = 0, ans_wr_in = 0;
  logic edge_wr_in = 0, pull_wr_in = 0, flag_wr_in = 0, global_ie_in = 0, module_en_in = 0;
  logic change_interrupt_flag_in = 0;
  logic [15:0] wdata_in = 0, dir_wdata_in = 0, odc_wdata_in = 0, ans_wdata_in = 0;
  logic [15:0] rise_wdata_in = 0, fall_wdata_in = 0, pu_wdata_in = 0, pd_wdata_in = 0;
  logic [15:0] flag_wdata_in = 0, periph_en_in = 0, periph_drive_in = 0, periph_out_in = 0;
  logic [15:0] ext = 0, ext_en = 0, own, drv, exp, lv;
  logic [15:0] pin_in, pin_out, pin_oe_out, periph_in_out, pullup_en_out, pulldown_en_out;
  logic [15:0] output_latch_bits_out, pin_direction_bits_out, pin_value_bits_out;
  logic [15:0] pin_change_flags_out;
  logic port_change_summary_flag_out;
  int seed = 32'h07df84a6;
  int n_mismatch = 0;
  int checks = 0;
  spio_port #(.IMPL_MASK(MASK)) DUT (.*);
  spio_pads pads (.mclk_in(mclk_in), .pad_data_in(pin_out), .pad_oe_in(pin_oe_out),
    .pu_in(pullup_en_out), .pd_in(pulldown_en_out), .drv_in(periph_en_in & periph_drive_in),
    .dval_in(periph_out_in), .ext_en_in(ext_en), .ext_in(ext), .level_out(pin_in));
  initial forever #2 mclk_in = ~mclk_in;
  task automatic chk(string name, logic [15:0] seen, logic [15:0] expv);
    checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, expv, seen);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      {lat_wr_in, port_wr_in, dir_wr_in, odc_wr_in, ans_wr_in, edge_wr_in, pull_wr_in} = '0;
      flag_wr_in = 0;
    end
  endtask : step
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    step(20);
    rst_in = 0;
    step(1);
    chk("dir", pin_direction_bits_out, MASK);
    chk("oe", pin_oe_out, '0);
    chk("pval", pin_value_bits_out, '0);
    ext_en = '1;
    for (int i = 0; i < 8; i++) begin
      wdata_in = $random(seed);
      dir_wdata_in = (i == 0) ? 16'h0000 : 16'($random(seed));
      odc_wdata_in = $random(seed);
      ans_wdata_in = $random(seed);
      periph_en_in = $random(seed);
      periph_drive_in = $random(seed);
      periph_out_in = $random(seed);
      ext = $random(seed);
      pu_wdata_in = $random(seed) & dir_wdata_in & MASK;
      pd_wdata_in = ~pu_wdata_in & dir_wdata_in & MASK;
      {lat_wr_in, port_wr_in} = i[0] ? 2'b10 : 2'b01;
      {dir_wr_in, odc_wr_in, ans_wr_in, pull_wr_in} = '1;
      step(1);
      own = ~(periph_en_in & periph_drive_in);
      drv = ~dir_wdata_in & MASK & own;
      exp = wdata_in & MASK;
      chk("latch", output_latch_bits_out, exp);
      chk("dir", pin_direction_bits_out, dir_wdata_in & MASK);
      chk("oe", pin_oe_out & own, drv & ~(odc_wdata_in & exp));
      chk("pin", pin_out & drv, exp & ~odc_wdata_in & drv);
      chk("pull", pullup_en_out ^ pulldown_en_out, dir_wdata_in & MASK);
      step(5);
      lv = (~own & periph_out_in) | (drv & exp & (~odc_wdata_in | ext)) | (own & ~drv & ext);
      chk("pval", pin_value_bits_out, lv & ~ans_wdata_in & MASK);
      chk("periph", periph_in_out & pin_oe_out & own, '0);
      chk("periph_in", periph_in_out, lv & ~ans_wdata_in & MASK & ~drv);
    end
    dir_wdata_in = '1;
    ans_wdata_in = '0;
    periph_en_in = '0;
    {dir_wr_in, ans_wr_in} = '1;
    step(8);
    for (int c = 0; c < 5; c++) begin
      rise_wdata_in = $random(seed);
      fall_wdata_in = (c == 0) ? rise_wdata_in : 16'($random(seed));
      {edge_wr_in, flag_wr_in, module_en_in} = 3'b110;
      flag_wdata_in = '0;
      step(6);
      {global_ie_in, module_en_in, change_interrupt_flag_in} = {c != 2, c != 3, c == 4};
      exp = ext;
      ext = $random(seed);
      step(6);
      lv = (c < 2) ? (rise_wdata_in & ext & ~exp | fall_wdata_in & exp & ~ext) & MASK : '0;
      chk("flags", pin_change_flags_out, lv);
      chk("sum", 16'(port_change_summary_flag_out), 16'(|lv));
      drv = ext;
      ext = exp;
      step(6);
      lv = (c < 2) ? (exp ^ drv) & (rise_wdata_in | fall_wdata_in) & MASK : '0;
      chk("both", pin_change_flags_out, lv);
      flag_wdata_in = $random(seed);
      flag_wr_in = 1;
      step(1);
      chk("clear", pin_change_flags_out, lv & flag_wdata_in);
    end
    rise_wdata_in = 16'h0001;
    fall_wdata_in = '0;
    ext = '0;
    {edge_wr_in, flag_wr_in, module_en_in} = 3'b110;
    flag_wdata_in = '0;
    step(6);
    {module_en_in, change_interrupt_flag_in} = 2'b10;
    step(1);
    ext = 16'h0001;
    step(4);
    flag_wr_in = 1;
    step(3);
    chk("race", pin_change_flags_out, 16'h0001);
    rst_in = 1;
    step(1);
    rst_in = 0;
    step(1);
    chk("dir", pin_direction_bits_out, MASK);
    chk("flags", pin_change_flags_out, '0);
    end_sim();
  end
endmodule : spio_port_tb
`default_nettype wire
